// [rtl/rxirq_regs.svh]
// register offsets, field positions, reset values and pulse counts of the receiver interrupt block
`ifndef RXIRQ_REGS_SVH
`define RXIRQ_REGS_SVH

// register byte offsets
`define RXIRQ_PIN_A_CTRL_ADDR 8'h40
`define RXIRQ_PIN_B_CTRL_ADDR 8'h41
`define RXIRQ_MAN_STATUS_ADDR 8'h48
`define RXIRQ_MAN_CLEAR_ADDR 8'h49
`define RXIRQ_MAN_PIN2_MASK_ADDR 8'h4a
`define RXIRQ_MAN_PIN1_MASK_ADDR 8'h4b
`define RXIRQ_SEEN_RAW_ADDR 8'h60
`define RXIRQ_SEEN_STATUS_ADDR 8'h61
`define RXIRQ_SEEN_CLEAR_ADDR 8'h62
`define RXIRQ_SEEN_PIN2_MASK_ADDR 8'h63
`define RXIRQ_SEEN_PIN1_MASK_ADDR 8'h64
`define RXIRQ_CHG_RAW_ADDR 8'h79
`define RXIRQ_CHG_STATUS_ADDR 8'h7a
`define RXIRQ_CHG_CLEAR_ADDR 8'h7b
`define RXIRQ_CHG_PIN2_MASK_ADDR 8'h7c
`define RXIRQ_CHG_PIN1_MASK_ADDR 8'h7d

// field positions
`define RXIRQ_LEN_MSB 7
`define RXIRQ_LEN_LSB 6
`define RXIRQ_MANUAL_BIT 2
`define RXIRQ_POL_BIT 2
`define RXIRQ_SEL_MSB 1
`define RXIRQ_SEL_LSB 0
`define RXIRQ_EVT_BIT 0
`define RXIRQ_MAN_MASK_BIT 7
`define RXIRQ_MAN_STATUS_BIT 0

// reset values
`define RXIRQ_LEN_RST 2'h0
`define RXIRQ_SEL_RST 2'h0
`define RXIRQ_BIT_RST 1'h0
`define RXIRQ_MASK_RST 3'h0

// pulse lengths in crystal periods, one clk_i cycle each
`define RXIRQ_PULSE_SHORT 7'h04
`define RXIRQ_PULSE_MID 7'h10
`define RXIRQ_PULSE_LONG 7'h40

`endif

// [rtl/rxirq_pkg.sv]
// types shared by the receiver interrupt block
package rxirq_pkg;

    // register access strobe group
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rxirq_bus_t;

    typedef enum logic [1:0] {
        RXIRQ_LEN_4 = 2'h0,
        RXIRQ_LEN_16 = 2'h1,
        RXIRQ_LEN_64 = 2'h2,
        RXIRQ_LEN_HOLD = 2'h3
    } rxirq_len_t;

    typedef enum logic [1:0] {
        RXIRQ_DRV_OPEN = 2'h0,
        RXIRQ_DRV_LOW = 2'h1,
        RXIRQ_DRV_HIGH = 2'h2,
        RXIRQ_DRV_OFF = 2'h3
    } rxirq_drive_t;

    typedef enum logic [1:0] {
        RXIRQ_ROUTE_OFF = 2'h0,
        RXIRQ_ROUTE_MCLK = 2'h1,
        RXIRQ_ROUTE_SCLK = 2'h2,
        RXIRQ_ROUTE_HPA = 2'h3
    } rxirq_route_t;

    // pulse generator states, one-hot
    typedef enum logic [2:0] {
        RXIRQ_ST_IDLE = 3'b001,
        RXIRQ_ST_ACTIVE = 3'b010,
        RXIRQ_ST_SPENT = 3'b100
    } rxirq_state_t;

    // software configuration fields
    typedef struct packed {
        rxirq_len_t pin1_pulse_length;
        logic manual_force_irq;
        rxirq_drive_t pin1_drive_mode;
        rxirq_len_t pin2_pulse_length;
        logic pin2_polarity;
        rxirq_route_t pin2_route_select;
    } rxirq_cfg_t;

endpackage : rxirq_pkg

// [rtl/rxirq_top.sv]
// receiver interrupt logic: raw, status, mask, clear bits and two interrupt pins
// Behaviour
// - status bit only sets while at least one of its two masks is set
// - status sets when raw bit changes, holds until clear, resets to 0
// - a set status bit stays high without time limit until cleared
// - clear bit self-clears; writing 1 clears status and any latched edge raw, 0 does nothing
// - level event raw bit is live, never latched
// - edge event raw bit latches until software writes its clear bit
// - per-event masks for pin one and pin two gate status and pin request
// - all mask bits reset to 0
// - pin one has its own pin, switched off only by its drive mode; pin two routed by 2-bit select, off at reset
// - pin one is high impedance after reset, open drain by default
// - pin one pulse length 4, 16, 64 periods or until cleared, reset 00
// - pin two has its own independent pulse length field
// - pin one drive: open drain, drive low, drive high, or disabled
// - pin two polarity bit: 0 high when active, 1 low when active
// - manual force bit makes a forced event, gated by its masks
// - manual event with pin one mask sets manual status and raises pin one
// - masked-in raw change sets status and raises the masked-in pin
// - further events before service cause no second pin assertion
`include "rxirq_regs.svh"

module rxirq_top
    import rxirq_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire rxirq_bus_t reg_bus_i,
    output logic [7:0] reg_rdata_o,
    input wire logic video_info_seen_raw_i,
    input wire logic video_info_changed_evt_i,
    input wire logic mclk_func_i,
    input wire logic sclk_func_i,
    input wire logic hot_plug_func_i,
    output logic irq_pin_a_o,
    output logic irq_pin_a_oe_o,
    output logic master_clock_shared_pin_o,
    output logic serial_clock_shared_pin_o,
    output logic hot_plug_shared_pin_o
);

    // event index: 0 info seen (level), 1 info changed (edge), 2 manual (edge)
    localparam int NEVT = 3;

    // cycles to load for a pulse length; counter runs down to zero
    function automatic logic [5:0] pulse_load(input rxirq_len_t len);
        logic [6:0] cycles;
        cycles = `RXIRQ_PULSE_SHORT;
        case (len)
            RXIRQ_LEN_16: cycles = `RXIRQ_PULSE_MID;
            RXIRQ_LEN_64: cycles = `RXIRQ_PULSE_LONG;
            default: cycles = `RXIRQ_PULSE_SHORT;
        endcase
        return cycles[5:0] - 6'h01;
    endfunction : pulse_load

    function automatic logic wr_hit(input rxirq_bus_t b, input logic [7:0] a);
        return b.wr_en && (b.addr == a);
    endfunction : wr_hit

    rxirq_cfg_t cfg_ff;
    logic [NEVT-1:0] mb1_ff;
    logic [NEVT-1:0] mb2_ff;
    logic [NEVT-1:0] status_ff;
    logic chg_raw_ff;
    logic man_raw_ff;
    logic seen_prev_ff;
    logic man_prev_ff;
    logic [7:0] rdata_ff;

    // decoded write strobes
    wire wr_ctrl_a = wr_hit(reg_bus_i, `RXIRQ_PIN_A_CTRL_ADDR);
    wire wr_ctrl_b = wr_hit(reg_bus_i, `RXIRQ_PIN_B_CTRL_ADDR);
    wire wdat_evt = reg_bus_i.wdata[`RXIRQ_EVT_BIT];
    wire wdat_man = reg_bus_i.wdata[`RXIRQ_MAN_MASK_BIT];
    wire wdat_mst = reg_bus_i.wdata[`RXIRQ_MAN_STATUS_BIT];
    wire [NEVT-1:0] clr;
    wire [NEVT-1:0] wr_mb1;
    wire [NEVT-1:0] wr_mb2;
    // clear bits store nothing, so they self-clear and read back 0
    assign clr[0] = wr_hit(reg_bus_i, `RXIRQ_SEEN_CLEAR_ADDR) && wdat_evt;
    assign clr[1] = wr_hit(reg_bus_i, `RXIRQ_CHG_CLEAR_ADDR) && wdat_evt;
    assign clr[2] = wr_hit(reg_bus_i, `RXIRQ_MAN_CLEAR_ADDR) && wdat_mst;
    assign wr_mb1[0] = wr_hit(reg_bus_i, `RXIRQ_SEEN_PIN1_MASK_ADDR);
    assign wr_mb1[1] = wr_hit(reg_bus_i, `RXIRQ_CHG_PIN1_MASK_ADDR);
    assign wr_mb1[2] = wr_hit(reg_bus_i, `RXIRQ_MAN_PIN1_MASK_ADDR);
    assign wr_mb2[0] = wr_hit(reg_bus_i, `RXIRQ_SEEN_PIN2_MASK_ADDR);
    assign wr_mb2[1] = wr_hit(reg_bus_i, `RXIRQ_CHG_PIN2_MASK_ADDR);
    assign wr_mb2[2] = wr_hit(reg_bus_i, `RXIRQ_MAN_PIN2_MASK_ADDR);
    wire [NEVT-1:0] wmask_bits = {wdat_man, wdat_evt, wdat_evt};

    // configuration fields
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_ff <= '{pin1_pulse_length: RXIRQ_LEN_4, manual_force_irq: `RXIRQ_BIT_RST,
                        pin1_drive_mode: RXIRQ_DRV_OPEN, pin2_pulse_length: RXIRQ_LEN_4,
                        pin2_polarity: `RXIRQ_BIT_RST, pin2_route_select: RXIRQ_ROUTE_OFF};
        end else begin
            if (wr_ctrl_a) begin
                cfg_ff.pin1_pulse_length <=
                    rxirq_len_t'(reg_bus_i.wdata[`RXIRQ_LEN_MSB:`RXIRQ_LEN_LSB]);
                cfg_ff.manual_force_irq <= reg_bus_i.wdata[`RXIRQ_MANUAL_BIT];
                cfg_ff.pin1_drive_mode <=
                    rxirq_drive_t'(reg_bus_i.wdata[`RXIRQ_SEL_MSB:`RXIRQ_SEL_LSB]);
            end
            if (wr_ctrl_b) begin
                cfg_ff.pin2_pulse_length <=
                    rxirq_len_t'(reg_bus_i.wdata[`RXIRQ_LEN_MSB:`RXIRQ_LEN_LSB]);
                cfg_ff.pin2_polarity <= reg_bus_i.wdata[`RXIRQ_POL_BIT];
                cfg_ff.pin2_route_select <=
                    rxirq_route_t'(reg_bus_i.wdata[`RXIRQ_SEL_MSB:`RXIRQ_SEL_LSB]);
            end
        end
    end

    // mask bits, all off after reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mb1_ff <= `RXIRQ_MASK_RST;
            mb2_ff <= `RXIRQ_MASK_RST;
        end else begin
            mb1_ff <= (wr_mb1 & wmask_bits) | (~wr_mb1 & mb1_ff);
            mb2_ff <= (wr_mb2 & wmask_bits) | (~wr_mb2 & mb2_ff);
        end
    end

    // event detection; manual event fires on the rise of the force bit
    wire man_evt = cfg_ff.manual_force_irq && !man_prev_ff;
    wire [NEVT-1:0] raw = {man_raw_ff, chg_raw_ff, video_info_seen_raw_i};
    // edge raws count as changed on their event pulse, so a repeat while latched is not lost
    wire [NEVT-1:0] chg = {man_evt, video_info_changed_evt_i,
                           video_info_seen_raw_i ^ seen_prev_ff};
    wire [NEVT-1:0] en = mb1_ff | mb2_ff;
    // set wins over a clear arriving in the same cycle
    wire [NEVT-1:0] nxt_status = (chg & en) | (status_ff & ~clr);
    wire nxt_chg_raw = video_info_changed_evt_i || (chg_raw_ff && !clr[1]);
    wire nxt_man_raw = man_evt || (man_raw_ff && !clr[2]);

    // raw latches and status bits
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_ff <= '0;
            chg_raw_ff <= 1'b0;
            man_raw_ff <= 1'b0;
            seen_prev_ff <= 1'b0;
            man_prev_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            chg_raw_ff <= nxt_chg_raw;
            man_raw_ff <= nxt_man_raw;
            seen_prev_ff <= video_info_seen_raw_i;
            man_prev_ff <= cfg_ff.manual_force_irq;
        end
    end

    // pin requests, index 0 pin one, 1 pin two
    wire [1:0] req;
    assign req[0] = |(status_ff & mb1_ff);
    assign req[1] = |(status_ff & mb2_ff);
    wire rxirq_len_t len_sel [2];
    assign len_sel[0] = cfg_ff.pin1_pulse_length;
    assign len_sel[1] = cfg_ff.pin2_pulse_length;

    rxirq_state_t state_ff [2];
    logic [5:0] cnt_ff [2];
    logic [1:0] active;

    // one pulse generator per pin; a spent pulse waits for its own pin request to drop
    for (genvar p = 0; p < 2; p++) begin : g_pulse
        rxirq_state_t nxt_state;
        logic [5:0] nxt_cnt;
        wire hold_mode = (len_sel[p] == RXIRQ_LEN_HOLD);
        always_comb begin
            nxt_state = state_ff[p];
            nxt_cnt = cnt_ff[p];
            case (state_ff[p])
                RXIRQ_ST_IDLE: begin
                    if (req[p]) begin
                        nxt_state = RXIRQ_ST_ACTIVE;
                        nxt_cnt = pulse_load(len_sel[p]);
                    end
                end
                RXIRQ_ST_ACTIVE: begin
                    if (hold_mode) begin
                        if (!req[p]) begin
                            nxt_state = RXIRQ_ST_IDLE;
                        end
                    end else if (cnt_ff[p] == 6'h00) begin
                        nxt_state = req[p] ? RXIRQ_ST_SPENT : RXIRQ_ST_IDLE;
                    end else begin
                        nxt_cnt = cnt_ff[p] - 6'h01;
                    end
                end
                RXIRQ_ST_SPENT: begin
                    if (!req[p]) begin
                        nxt_state = RXIRQ_ST_IDLE;
                    end
                end
                default: nxt_state = RXIRQ_ST_IDLE;
            endcase
        end
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                state_ff[p] <= RXIRQ_ST_IDLE;
                cnt_ff[p] <= 6'h00;
            end else begin
                state_ff[p] <= nxt_state;
                cnt_ff[p] <= nxt_cnt;
            end
        end
        assign active[p] = (state_ff[p] == RXIRQ_ST_ACTIVE);
    end

    // pin drive decode
    wire drv_od = cfg_ff.pin1_drive_mode == RXIRQ_DRV_OPEN;
    wire drv_lo = cfg_ff.pin1_drive_mode == RXIRQ_DRV_LOW;
    wire drv_hi = cfg_ff.pin1_drive_mode == RXIRQ_DRV_HIGH;
    wire nxt_a_oe = (drv_od && active[0]) || drv_lo || drv_hi;
    wire nxt_a_o = drv_hi ? active[0] : (drv_lo ? !active[0] : 1'b0);
    wire lvl_b = active[1] ^ cfg_ff.pin2_polarity;
    wire rxirq_route_t route = cfg_ff.pin2_route_select;
    // shared pins keep their own function unless pin two is routed there
    wire nxt_mclk = (route == RXIRQ_ROUTE_MCLK) ? lvl_b : mclk_func_i;
    wire nxt_sclk = (route == RXIRQ_ROUTE_SCLK) ? lvl_b : sclk_func_i;
    wire nxt_hpa = (route == RXIRQ_ROUTE_HPA) ? lvl_b : hot_plug_func_i;

    // registered pin outputs, one cycle behind the pulse state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_pin_a_o <= 1'b0;
            irq_pin_a_oe_o <= 1'b0;
            master_clock_shared_pin_o <= 1'b0;
            serial_clock_shared_pin_o <= 1'b0;
            hot_plug_shared_pin_o <= 1'b0;
        end else begin
            irq_pin_a_o <= nxt_a_o;
            irq_pin_a_oe_o <= nxt_a_oe;
            master_clock_shared_pin_o <= nxt_mclk;
            serial_clock_shared_pin_o <= nxt_sclk;
            hot_plug_shared_pin_o <= nxt_hpa;
        end
    end

    // read mux; clear registers and unmapped offsets read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_bus_i.addr)
            `RXIRQ_PIN_A_CTRL_ADDR: rd_mux = {cfg_ff.pin1_pulse_length, 3'h0,
                                              cfg_ff.manual_force_irq, cfg_ff.pin1_drive_mode};
            `RXIRQ_PIN_B_CTRL_ADDR: rd_mux = {cfg_ff.pin2_pulse_length, 3'h0,
                                              cfg_ff.pin2_polarity, cfg_ff.pin2_route_select};
            `RXIRQ_MAN_STATUS_ADDR: rd_mux = {7'h00, status_ff[2]};
            `RXIRQ_MAN_PIN2_MASK_ADDR: rd_mux = {mb2_ff[2], 7'h00};
            `RXIRQ_MAN_PIN1_MASK_ADDR: rd_mux = {mb1_ff[2], 7'h00};
            `RXIRQ_SEEN_RAW_ADDR: rd_mux = {7'h00, raw[0]};
            `RXIRQ_SEEN_STATUS_ADDR: rd_mux = {7'h00, status_ff[0]};
            `RXIRQ_SEEN_PIN2_MASK_ADDR: rd_mux = {7'h00, mb2_ff[0]};
            `RXIRQ_SEEN_PIN1_MASK_ADDR: rd_mux = {7'h00, mb1_ff[0]};
            `RXIRQ_CHG_RAW_ADDR: rd_mux = {7'h00, raw[1]};
            `RXIRQ_CHG_STATUS_ADDR: rd_mux = {7'h00, status_ff[1]};
            `RXIRQ_CHG_PIN2_MASK_ADDR: rd_mux = {7'h00, mb2_ff[1]};
            `RXIRQ_CHG_PIN1_MASK_ADDR: rd_mux = {7'h00, mb1_ff[1]};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= 8'h00;
        end else if (reg_bus_i.rd_en) begin
            rdata_ff <= rd_mux;
        end
    end
    assign reg_rdata_o = rdata_ff;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    property p_status_mask_gate;
        !en[0] && !status_ff[0] |=> !status_ff[0];
    endproperty
    a_status_mask_gate: assert property (p_status_mask_gate)
        else $error("status set with both masks clear");

    property p_status_set;
        chg[1] && en[1] |=> status_ff[1];
    endproperty
    a_status_set: assert property (p_status_set)
        else $error("status not set after masked event");

    property p_status_hold;
        status_ff[0] && !clr[0] |=> status_ff[0];
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("status dropped without clear");

    property p_clear_raw;
        clr[1] && !video_info_changed_evt_i && !(chg[1] && en[1])
            |=> !chg_raw_ff && !status_ff[1];
    endproperty
    a_clear_raw: assert property (p_clear_raw)
        else $error("clear did not reset raw and status");

    property p_edge_latch;
        $rose(chg_raw_ff) && !clr[1] |=> chg_raw_ff;
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("edge raw bit not latched");

    sequence s_start_a;
        state_ff[0] == RXIRQ_ST_IDLE && req[0] && len_sel[0] == RXIRQ_LEN_4;
    endsequence
    sequence s_four_active;
        active[0] [*4] ##1 !active[0];
    endsequence
    property p_pulse4;
        s_start_a |=> s_four_active;
    endproperty
    a_pulse4: assert property (p_pulse4)
        else $error("pin one short pulse length wrong");

    sequence s_start_b;
        state_ff[1] == RXIRQ_ST_IDLE && req[1] && len_sel[1] == RXIRQ_LEN_16;
    endsequence
    property p_pulse16;
        s_start_b |=> active[1] [*8] ##1 active[1] [*8] ##1 !active[1];
    endproperty
    a_pulse16: assert property (p_pulse16)
        else $error("pin two mid pulse length wrong");

    property p_open_drain;
        drv_od && !active[0] |=> !irq_pin_a_oe_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open drain pin driven while idle");

    property p_drive_high;
        drv_hi && active[0] |=> irq_pin_a_oe_o && irq_pin_a_o;
    endproperty
    a_drive_high: assert property (p_drive_high)
        else $error("drive high mode not driving high");

    property p_polarity;
        route == RXIRQ_ROUTE_MCLK |=> master_clock_shared_pin_o == $past(lvl_b);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin two level wrong on routed pin");

    property p_route_off;
        route == RXIRQ_ROUTE_OFF |=> hot_plug_shared_pin_o == $past(hot_plug_func_i);
    endproperty
    a_route_off: assert property (p_route_off)
        else $error("pin two present while disabled");

    property p_no_restart;
        state_ff[0] == RXIRQ_ST_SPENT && req[0] |=> !active[0];
    endproperty
    a_no_restart: assert property (p_no_restart)
        else $error("pulse restarted before service");

    property p_manual;
        man_evt && mb1_ff[2] |=> status_ff[2] && req[0];
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual event did not reach pin one");

endmodule : rxirq_top

// [verification/rxirq_host_model.sv]
// host controller model: resolves both interrupt pins and measures their pulses
module rxirq_host_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pin_a_o_i,
    input wire logic pin_a_oe_i,
    input wire logic pin_a_act_high_i,
    input wire logic pin_b_level_i,
    input wire logic pin_b_pol_i,
    output logic [7:0] width_a_o,
    output logic [7:0] width_b_o,
    output logic [7:0] count_a_o,
    output logic [7:0] count_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lvl_a;
    logic act_a;
    logic act_b;
    logic [7:0] run_a;
    logic [7:0] run_b;
    // board pull-up on pin one: a released line reads high, never the old value
    assign lvl_a = pin_a_oe_i ? pin_a_o_i : 1'b1;
    assign act_a = (lvl_a == pin_a_act_high_i);
    assign act_b = pin_b_level_i ^ pin_b_pol_i;
    // width is latched when a pulse ends, so hold-mode pulses count only once cleared
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_a <= 8'h00;
            run_b <= 8'h00;
            width_a_o <= 8'h00;
            width_b_o <= 8'h00;
            count_a_o <= 8'h00;
            count_b_o <= 8'h00;
        end else begin
            run_a <= act_a ? run_a + 8'h01 : 8'h00;
            run_b <= act_b ? run_b + 8'h01 : 8'h00;
            if (!act_a && run_a != 8'h00) begin
                width_a_o <= run_a;
                count_a_o <= count_a_o + 8'h01;
            end
            if (!act_b && run_b != 8'h00) begin
                width_b_o <= run_b;
                count_b_o <= count_b_o + 8'h01;
            end
        end
    end
endmodule : rxirq_host_model

// [verification/tb_top.sv]
// self-checking bench of the receiver interrupt block
module tb_top;
    import rxirq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, nrst_i, seen, chg, pa_o, pa_oe, mck, sck, hpa, pol, pin_b_lvl, p;
    rxirq_bus_t bus;
    logic [7:0] rdata, wa, wb, ca_n, cb_n, c0, c1;
    logic [2:0] fn;
    logic [1:0] route, l;
    logic [31:0] seed;
    int errors, num_checks, cyc;
    logic [7:0] rst_tab [17] = '{8'h40, 8'h41, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h60, 8'h61,
        8'h62, 8'h63, 8'h64, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h50};
    rxirq_top rxirq_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .reg_bus_i(bus),
        .reg_rdata_o(rdata), .video_info_seen_raw_i(seen), .video_info_changed_evt_i(chg),
        .mclk_func_i(fn[2]), .sclk_func_i(fn[1]), .hot_plug_func_i(fn[0]),
        .irq_pin_a_o(pa_o), .irq_pin_a_oe_o(pa_oe), .master_clock_shared_pin_o(mck),
        .serial_clock_shared_pin_o(sck), .hot_plug_shared_pin_o(hpa));
    // host sees pin two on whichever shared pin is routed
    assign pin_b_lvl = (route == 2'h1) ? mck : (route == 2'h2) ? sck : hpa;
    rxirq_host_model rxirq_host_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .pin_a_o_i(pa_o),
        .pin_a_oe_i(pa_oe), .pin_a_act_high_i(1'b0), .pin_b_level_i(pin_b_lvl),
        .pin_b_pol_i(pol), .width_a_o(wa), .width_b_o(wb), .count_a_o(ca_n), .count_b_o(cb_n));
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    function automatic logic [7:0] len(input logic [1:0] c);
        return (c == 2'h0) ? 8'd4 : (c == 2'h1) ? 8'd16 : 8'd64;
    endfunction : len
    // expected {oe, o} of pin one per drive mode
    function automatic logic [7:0] drv(input logic [1:0] m, input logic act);
        case (m)
            2'h0: return {6'h0, act, 1'b0};
            2'h1: return {6'h0, 1'b1, ~act};
            2'h2: return {6'h0, 1'b1, act};
            default: return 8'h00;
        endcase
    endfunction : drv
    task automatic chk(input logic [7:0] seen_v, input logic [7:0] exp_v);
        num_checks++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus.wr_en <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        bus <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        bus.rd_en <= 1'b0;
        #1;
        chk(rdata, e);
    endtask : rdchk
    task automatic fire();
        @(posedge clk_i);
        chg <= 1'b1;
        @(posedge clk_i);
        chg <= 1'b0;
    endtask : fire
    // bounded wait for the host to see one more finished pulse
    task automatic wait_cnt(input logic ch, input logic [7:0] old);
        int n;
        n = 0;
        while (((ch ? cb_n : ca_n) === old) && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        // a pulse that never ends is a failure, not a silent pass
        if (n >= 300) errors++;
        #1;
    endtask : wait_cnt
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // hang guard, well above the length of all tests
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        nrst_i = 1'b0;
        bus = '0;
        {seen, chg, pol, route, fn, errors, num_checks, cyc} = '0;
        seed = 32'h5b571f72;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        chk({6'h0, pa_oe, pa_o}, 8'h00);
        foreach (rst_tab[i]) rdchk(rst_tab[i], 8'h00);
        wr(8'h61, 8'h01);
        rdchk(8'h61, 8'h00);
        $display("test reset done");
        // an event with both masks clear must leave status alone
        c0 = ca_n;
        fire();
        repeat (10) @(posedge clk_i);
        rdchk(8'h7a, 8'h00);
        chk(ca_n, c0);
        wr(8'h7b, 8'h01);
        $display("test masked done");
        // timed pulses on pin one, with a second event arriving mid-pulse
        wr(8'h7d, 8'h01);
        for (int k = 0; k < 3; k++) begin
            l = k[1:0];
            wr(8'h40, {l, 6'h00});
            c0 = ca_n;
            fire();
            seed = xs(seed);
            repeat (1 + seed[1:0]) @(posedge clk_i);
            fire();
            wait_cnt(1'b0, c0);
            chk(wa, len(l));
            repeat (30) @(posedge clk_i);
            chk(ca_n, c0 + 8'h01);
            rdchk(8'h7a, 8'h01);
            rdchk(8'h79, 8'h01);
            wr(8'h7b, 8'h00);
            rdchk(8'h7a, 8'h01);
            wr(8'h7b, 8'h01);
            rdchk(8'h7a, 8'h00);
            rdchk(8'h79, 8'h00);
            rdchk(8'h7b, 8'h00);
        end
        wr(8'h7d, 8'h00);
        $display("test pulse length done");
        // live level event in hold mode, every drive mode
        wr(8'h64, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(8'h40, {6'h30, m[1:0]});
            @(posedge clk_i);
            seen <= 1'b1;
            repeat (6) @(posedge clk_i);
            #1;
            chk({6'h0, pa_oe, pa_o}, drv(m[1:0], 1'b1));
            rdchk(8'h60, 8'h01);
            @(posedge clk_i);
            seen <= 1'b0;
            repeat (80) @(posedge clk_i);
            #1;
            chk({6'h0, pa_oe, pa_o}, drv(m[1:0], 1'b1));
            rdchk(8'h60, 8'h00);
            rdchk(8'h61, 8'h01);
            wr(8'h62, 8'h01);
            repeat (5) @(posedge clk_i);
            #1;
            chk({6'h0, pa_oe, pa_o}, drv(m[1:0], 1'b0));
        end
        wr(8'h64, 8'h00);
        wr(8'h40, 8'h00);
        $display("test drive mode done");
        // pin two on each shared pin, random length and polarity
        seed = xs(seed);
        @(posedge clk_i);
        fn <= seed[2:0];
        wr(8'h7c, 8'h01);
        for (int r = 1; r < 4; r++) begin
            seed = xs(seed);
            l = 2'(seed[7:0] % 8'd3);
            p = seed[9];
            wr(8'h41, {l, 3'h0, p, r[1:0]});
            route = r[1:0];
            pol = p;
            repeat (4) @(posedge clk_i);
            c0 = cb_n;
            c1 = ca_n;
            fire();
            wait_cnt(1'b1, c0);
            chk(wb, len(l));
            chk(ca_n, c1);
            c0 = {5'h0, fn};
            c0[3 - r] = p;
            chk({5'h0, mck, sck, hpa}, c0);
            wr(8'h7b, 8'h01);
        end
        wr(8'h41, 8'h00);
        repeat (4) @(posedge clk_i);
        #1;
        chk({5'h0, mck, sck, hpa}, {5'h0, fn});
        wr(8'h7c, 8'h00);
        $display("test pin two done");
        // manual forced interrupt, a test-only feature, first without then with mask
        wr(8'h40, 8'h04);
        c0 = ca_n;
        repeat (10) @(posedge clk_i);
        chk(ca_n, c0);
        rdchk(8'h48, 8'h00);
        wr(8'h49, 8'h01);
        wr(8'h40, 8'h00);
        wr(8'h4b, 8'h80);
        wr(8'h40, 8'h04);
        wait_cnt(1'b0, c0);
        chk(wa, 8'd4);
        rdchk(8'h48, 8'h01);
        wr(8'h49, 8'h01);
        rdchk(8'h48, 8'h00);
        // pin two masks of the level and manual events read back as written
        wr(8'h4a, 8'h80);
        rdchk(8'h4a, 8'h80);
        wr(8'h63, 8'h01);
        rdchk(8'h63, 8'h01);
        $display("test manual done");
        end_of_test();
    end
endmodule : tb_top
